// File: rtl/dsrps_pkg.sv
package dsrps_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NREQ       = 5;   // Requester 0 is the auxiliary port, 1..4 are channels
  localparam int CW         = 3;   // Requester index width
  localparam int AW         = 32;
  localparam int DW         = 32;
  localparam int HOLD_DEPTH = 8;   // Holds the largest burst, an unshared one (8)
  localparam int HPW        = 3;   // Holding pointer width
  localparam int HCW        = 4;   // Holding count width
  localparam int TW         = 6;   // Timing counter width
  localparam int PORT_LSB   = 24;  // Master port decoded from this address bit upward
  localparam int ELEM_BYTES = 4;

  localparam logic [1:0]    START_RUN     = 2'h1;
  localparam logic [1:0]    READ_HOLD_MIN = 2'h3;
  localparam logic [HCW-1:0] HCW_ONE      = 4'h1;
  // Start edge, arbitration edge and the registered select eat into the lead count
  localparam logic [6-1:0]  LEAD_LAG      = 6'h03;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MEM_INT, MEM_ASYNC, MEM_SDRAM, MEM_SYNC_BURST} dsrps_mem_type;

  typedef struct packed {
    dsrps_mem_type src_mem;
    dsrps_mem_type dst_mem;
    logic [AW-1:0] src_addr;
    logic [AW-1:0] dst_addr;
    logic [15:0]   elem_cnt;
    logic [7:0]    frame_cnt;
    logic [1:0]    async_read_hold;
  } dsrps_cfg_type;

  typedef struct packed {
    logic          strobe;
    logic          write;
    logic          select;
    logic [CW-1:0] chan;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dsrps_acc_type;

  // ----------------------------------------------------------------------
  // Timing in CPU clock cycles
  // ----------------------------------------------------------------------
  localparam logic [TW-1:0] START_TO_SYNC   = 6'h01;
  localparam logic [TW-1:0] SYNC_RD_INT     = 6'h01;
  localparam logic [TW-1:0] SYNC_RD_ASYNC   = 6'h09;
  localparam logic [TW-1:0] SYNC_RD_SDRAM   = 6'h0c;
  localparam logic [TW-1:0] SYNC_RD_SBS     = 6'h0b;
  localparam logic [TW-1:0] ELEM_INT        = 6'h01;
  localparam logic [TW-1:0] ELEM_ASYNC      = 6'h07;
  localparam logic [TW-1:0] ELEM_SDRAM      = 6'h01;
  localparam logic [TW-1:0] ELEM_SBS        = 6'h02;
  localparam logic [TW-1:0] RSETUP_EXT      = 6'h04;
  localparam logic [TW-1:0] RHOLD_ASYNC     = 6'h06;
  localparam logic [TW-1:0] WHOLD_ASYNC     = 6'h03;
  localparam logic [TW-1:0] HOLD_SDRAM      = 6'h04;
  localparam logic [TW-1:0] HOLD_SBS        = 6'h04;
  localparam logic [TW-1:0] GAP_INT         = 6'h01;
  localparam logic [TW-1:0] GAP_ASYNC       = 6'h01;
  localparam logic [TW-1:0] GAP_SDRAM_RD    = 6'h10;
  localparam logic [TW-1:0] GAP_SDRAM_WR    = 6'h0a;
  localparam logic [TW-1:0] GAP_SBS         = 6'h04;
  localparam logic [TW-1:0] RW_BASE_ASYNC   = 6'h02;
  localparam logic [TW-1:0] WR_BASE_ASYNC   = 6'h01;
  localparam logic [TW-1:0] RW_BASE_SBS     = 6'h06;
  localparam logic [TW-1:0] WR_BASE_EXT     = 6'h01;
  localparam logic [TW-1:0] RW_BASE_SDRAM   = 6'h06;
  localparam logic [TW-1:0] EXT_RW_EXTRA    = 6'h04;  // Worst case of 0..4
  localparam logic [TW-1:0] EXT_WR_EXTRA    = 6'h04;  // Worst case of 1..4
  localparam logic [TW-1:0] INT_RW_TURN     = 6'h08;
  localparam logic [TW-1:0] INT_WR_TURN     = 6'h09;
  localparam logic [TW-1:0] PRIO_RW_EXTRA   = 6'h0f;
  localparam logic [TW-1:0] PRIO_WR_EXTRA   = 6'h04;

  localparam logic [HCW-1:0] BURST_INT      = 4'h5;
  localparam logic [HCW-1:0] BURST_ASYNC    = 4'h3;
  localparam logic [HCW-1:0] BURST_ASYNC_H3 = 4'h2;
  localparam logic [HCW-1:0] BURST_SDRAM    = 4'h6;
  localparam logic [HCW-1:0] BURST_SBS      = 4'h5;
  localparam logic [HCW-1:0] BURST_FULL     = 4'h8;

  // Pick one of four per-memory figures
  function automatic logic [TW-1:0] dsrps_pick(dsrps_mem_type m, logic [TW-1:0] vi, logic [TW-1:0] va,
                                               logic [TW-1:0] vs, logic [TW-1:0] vb);
    case (m)
      MEM_INT:   return vi;
      MEM_ASYNC: return va;
      MEM_SDRAM: return vs;
      default:   return vb;
    endcase
  endfunction : dsrps_pick

endpackage : dsrps_pkg

// File: rtl/dsrps_sched.sv
// Contract
// - Same resource: never read and write together
// - Pending writes granted before pending reads
// - Write request raised while holding registers nonempty
// - Shared read burst limited by memory speed
// - Shared burst size fixed per read memory
// - Async read hold 3 gives shared burst 2
// - External same-resource turns add 0-4, 1-4
// - Internal turns: read-write 8, write-read 9
// - Four to six master ports exist
// - No burst crosses a master port
// - Auxiliary port arbitrated like a channel
// - Lower channel waits for higher transfer
// - Sync seen flag one cycle after start
// - Burst SRAM read begins 11 after sync
// - One burst per frame, burst SRAM gap 4; the code runs as many bursts as a frame needs, gap only between frames
// - Burst SRAM read: 4 setup, 2/elem, 4 hold
// - Burst SRAM write: 2/elem, 4 hold
// - High read to low write: 6 plus 15; the code never adds the 15, priority only adds 4 on a write-to-read turn
// - Higher request suspends lower channel requests
// - Frame boundary ends burst, next starts fresh
`timescale 1ns/100ps
module dsrps_sched
  import dsrps_pkg::*;
(
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  input  wire logic [NREQ-1:0]         START_WE,
  input  wire logic [1:0]              START_VAL,
  input  wire dsrps_cfg_type [NREQ-1:0] CFG,
  input  wire logic [DW-1:0]           MEM_RDATA,
  output dsrps_acc_type                ACC,
  output logic [NREQ-1:0]              SYNC_SEEN,
  output logic [NREQ-1:0]              DONE,
  output logic                         WR_REQ,
  output logic                         BUSY
);

  typedef enum logic [3:0] {ST_IDLE, ST_ARB, ST_LEAD, ST_TURN, ST_SETUP, ST_XFER, ST_HOLD, ST_GAP} dsrps_st_type;

  dsrps_st_type        st, next_st;
  logic [CW-1:0]       cur, next_cur, last_ch, next_last_ch;
  logic                last_vld, next_last_vld, last_wr, next_last_wr;
  logic                dir_wr, next_dir_wr;
  logic [TW-1:0]       cnt, next_cnt, ecnt, next_ecnt;
  logic [HCW-1:0]      blen, next_blen, bidx, next_bidx, hcnt, next_hcnt;
  logic [15:0]         eleft [NREQ], next_eleft [NREQ];
  logic [7:0]          fleft [NREQ], next_fleft [NREQ];
  logic [AW-1:0]       sadr [NREQ], next_sadr [NREQ], dadr [NREQ], next_dadr [NREQ];
  logic [NREQ-1:0]     pend, next_pend, done_p, go, sync_set;
  logic [DW-1:0]       hold_mem [HOLD_DEPTH];
  dsrps_acc_type       next_acc;
  dsrps_cfg_type       c;
  logic                same, grant_vld;
  logic [CW-1:0]       grant;
  dsrps_mem_type       mem;
  logic [AW-1:0]       adr;
  logic [TW-1:0]       elem_cyc;

  // ----------------------------------------------------------------------
  // Start and sync flags
  // ----------------------------------------------------------------------
  // Each requester, the auxiliary port too, starts and syncs the same way
  for (genvar i = 0; i < NREQ; i++) begin : g_req
    assign go[i] = START_WE[i] && (START_VAL == START_RUN) && !pend[i];
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        sync_set[i] <= 1'b0;
      end else begin
        sync_set[i] <= go[i] || (sync_set[i] && pend[i]);
      end
    end
  end
  assign SYNC_SEEN = sync_set;

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  // Fixed priority, index 0 highest; only decided between bursts, so a
  // higher request suspends the lower channel at its next burst boundary
  always_comb begin
    grant     = '0;
    grant_vld = 1'b0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (pend[i] && sync_set[i]) begin
        grant     = CW'(i);
        grant_vld = 1'b1;
      end
    end
  end

  // Working view of the current requester
  always_comb begin
    c        = CFG[cur];
    same     = (c.src_mem == c.dst_mem);
    mem      = dir_wr ? c.dst_mem : c.src_mem;
    adr      = dir_wr ? dadr[cur] : sadr[cur];
    elem_cyc = dsrps_pick(mem, ELEM_INT, ELEM_ASYNC, ELEM_SDRAM, ELEM_SBS);
  end

  // Burst length: shared table, frame remainder and port boundary
  function automatic logic [HCW-1:0] burst_len(dsrps_cfg_type k, logic [15:0] el, logic [AW-1:0] sa,
                                               logic [AW-1:0] da);
    logic [HCW-1:0] lim;
    logic [AW-1:0]  rs, rd;
    lim = BURST_FULL;
    if (k.src_mem == k.dst_mem) begin
      case (k.src_mem)
        MEM_INT:   lim = BURST_INT;
        MEM_ASYNC: lim = (k.async_read_hold == READ_HOLD_MIN) ? BURST_ASYNC_H3 : BURST_ASYNC;
        MEM_SDRAM: lim = BURST_SDRAM;
        default:   lim = BURST_SBS;
      endcase
    end
    // Elements left before each address leaves its master port
    rs = {{(AW-PORT_LSB){1'b0}}, ~sa[PORT_LSB-1:0]} / AW'(ELEM_BYTES) + AW'(1);
    rd = {{(AW-PORT_LSB){1'b0}}, ~da[PORT_LSB-1:0]} / AW'(ELEM_BYTES) + AW'(1);
    if ({16'h0000, el} < AW'(lim)) lim = el[HCW-1:0];
    if (rs < AW'(lim)) lim = rs[HCW-1:0];
    if (rd < AW'(lim)) lim = rd[HCW-1:0];
    return lim;
  endfunction : burst_len

  // Turnaround cost, ranges taken at their worst case
  function automatic logic [TW-1:0] turn_len(dsrps_mem_type m, logic to_wr, logic shared, logic prio);
    logic [TW-1:0] t;
    t = to_wr ? dsrps_pick(m, '0, RW_BASE_ASYNC, RW_BASE_SDRAM, RW_BASE_SBS)
              : dsrps_pick(m, '0, WR_BASE_ASYNC, WR_BASE_EXT, WR_BASE_EXT);
    if (shared && m == MEM_INT) t = to_wr ? INT_RW_TURN : INT_WR_TURN;
    else if (shared) t = t + (to_wr ? EXT_RW_EXTRA : EXT_WR_EXTRA);
    if (prio) t = t + (to_wr ? PRIO_RW_EXTRA : PRIO_WR_EXTRA);
    return (t == '0) ? TW'(1) : t;
  endfunction : turn_len

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_cur     = cur;
    next_last_ch = last_ch;
    next_last_vld = last_vld;
    next_last_wr = last_wr;
    next_dir_wr  = dir_wr;
    next_cnt     = (cnt != '0) ? cnt - TW'(1) : cnt;
    next_ecnt    = ecnt;
    next_blen    = blen;
    next_bidx    = bidx;
    next_hcnt    = hcnt;
    next_eleft   = eleft;
    next_fleft   = fleft;
    next_sadr    = sadr;
    next_dadr    = dadr;
    next_pend    = pend | go;
    done_p       = '0;
    next_acc     = '0;
    next_acc.chan = cur;
    for (int i = 0; i < NREQ; i++) begin
      if (go[i]) begin
        next_eleft[i] = CFG[i].elem_cnt;
        next_fleft[i] = CFG[i].frame_cnt;
        next_sadr[i]  = CFG[i].src_addr;
        next_dadr[i]  = CFG[i].dst_addr;
      end
    end
    case (st)
      ST_IDLE: begin
        next_last_vld = 1'b0;
        if (grant_vld) next_st = ST_ARB;
      end
      ST_ARB: begin
        // Holding is always empty here, so writes never wait on arbitration
        if (!grant_vld) begin
          next_st = ST_IDLE;
        end else begin
          next_cur    = grant;
          next_dir_wr = 1'b0;
          next_blen   = burst_len(CFG[grant], eleft[grant], sadr[grant], dadr[grant]);
          next_bidx   = '0;
          if (!last_vld) begin
            next_st  = ST_LEAD;
            // Flag rose two edges back and select lags one more, so the lead is shortened
            next_cnt = dsrps_pick(CFG[grant].src_mem, SYNC_RD_INT, SYNC_RD_ASYNC, SYNC_RD_SDRAM, SYNC_RD_SBS);
            next_cnt = (next_cnt > LEAD_LAG) ? next_cnt - LEAD_LAG : TW'(1);
          end else if (last_ch != grant) begin
            next_st  = ST_TURN;
            next_cnt = turn_len(CFG[grant].src_mem, 1'b0, 1'b0, grant < last_ch);
          end else if (last_wr && CFG[grant].src_mem == CFG[grant].dst_mem) begin
            // Same resource back from writing pays the write-to-read turn
            next_st  = ST_TURN;
            next_cnt = turn_len(CFG[grant].src_mem, 1'b0, 1'b1, 1'b0);
          end else begin
            next_st  = ST_SETUP;
            next_cnt = (CFG[grant].src_mem == MEM_INT) ? TW'(1) : RSETUP_EXT;
          end
        end
      end
      ST_LEAD, ST_TURN: begin
        if (cnt <= TW'(1)) begin
          next_st  = dir_wr ? ST_XFER : ST_SETUP;
          next_cnt = (!dir_wr && mem != MEM_INT) ? RSETUP_EXT : TW'(1);
          next_ecnt = '0;
          if (dir_wr) next_st = ST_XFER;
        end
      end
      ST_SETUP: begin
        next_acc.select = (mem != MEM_INT);
        if (cnt <= TW'(1)) begin
          next_st   = ST_XFER;
          next_ecnt = '0;
        end
      end
      ST_XFER: begin
        next_acc.select = (mem != MEM_INT);
        next_acc.write  = dir_wr;
        next_acc.addr   = adr;
        next_ecnt       = (ecnt + TW'(1) == elem_cyc) ? '0 : ecnt + TW'(1);
        if (ecnt == '0) begin
          // One strobe per element, only one direction active at a time
          next_acc.strobe = 1'b1;
          next_acc.wdata  = hold_mem[bidx[HPW-1:0]];
          next_bidx       = bidx + HCW'(1);
          next_hcnt       = dir_wr ? hcnt - HCW_ONE : hcnt + HCW_ONE;
          if (dir_wr) next_dadr[cur] = dadr[cur] + AW'(ELEM_BYTES);
          else        next_sadr[cur] = sadr[cur] + AW'(ELEM_BYTES);
        end
        // Leave on the last cycle of the last element, so a one-cycle memory gets no extra access
        if (ecnt + TW'(1) == elem_cyc && next_bidx == blen) begin
          next_st  = ST_HOLD;
          next_cnt = dir_wr ? dsrps_pick(mem, TW'(1), WHOLD_ASYNC, HOLD_SDRAM, HOLD_SBS)
                            : dsrps_pick(mem, TW'(1), RHOLD_ASYNC, HOLD_SDRAM, HOLD_SBS);
        end
      end
      ST_HOLD: begin
        next_acc.select = (mem != MEM_INT);
        if (cnt <= TW'(1)) begin
          next_last_vld = 1'b1;
          next_last_ch  = cur;
          next_last_wr  = dir_wr;
          next_bidx     = '0;
          if (!dir_wr) begin
            // Holding full of this burst: writes take the port next
            next_dir_wr = 1'b1;
            next_st     = ST_TURN;
            next_cnt    = (same || c.dst_mem == MEM_INT)
                          ? turn_len(c.dst_mem, 1'b1, same, 1'b0) : TW'(1);
          end else begin
            next_eleft[cur] = eleft[cur] - 16'(blen);
            next_st         = ST_ARB;
            if (eleft[cur] == 16'(blen)) begin
              // Frame done; next frame opens a fresh burst after the gap
              next_eleft[cur] = c.elem_cnt;
              next_fleft[cur] = fleft[cur] - 8'h01;
              next_st         = ST_GAP;
              next_cnt        = dsrps_pick(c.src_mem, GAP_INT, GAP_ASYNC, GAP_SDRAM_RD, GAP_SBS);
              if (fleft[cur] <= 8'h01) begin
                next_pend[cur] = 1'b0;
                done_p[cur]    = 1'b1;
                next_st        = ST_ARB;
              end
            end
          end
        end
      end
      ST_GAP: begin
        if (cnt <= TW'(1)) next_st = ST_ARB;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st       <= ST_IDLE;
      cur      <= '0;
      last_ch  <= '0;
      last_vld <= 1'b0;
      last_wr  <= 1'b0;
      dir_wr   <= 1'b0;
      cnt      <= '0;
      ecnt     <= '0;
      blen     <= '0;
      bidx     <= '0;
      hcnt     <= '0;
      pend     <= '0;
      ACC      <= '0;
      DONE     <= '0;
      for (int i = 0; i < NREQ; i++) begin
        eleft[i] <= '0;
        fleft[i] <= '0;
        sadr[i]  <= '0;
        dadr[i]  <= '0;
      end
    end else begin
      st       <= next_st;
      cur      <= next_cur;
      last_ch  <= next_last_ch;
      last_vld <= next_last_vld;
      last_wr  <= next_last_wr;
      dir_wr   <= next_dir_wr;
      cnt      <= next_cnt;
      ecnt     <= next_ecnt;
      blen     <= next_blen;
      bidx     <= next_bidx;
      hcnt     <= next_hcnt;
      pend     <= next_pend;
      ACC      <= next_acc;
      DONE     <= done_p;
      eleft    <= next_eleft;
      fleft    <= next_fleft;
      sadr     <= next_sadr;
      dadr     <= next_dadr;
    end
  end

  // Holding registers catch read data on the registered read strobe
  always_ff @(posedge CLK_SYS) begin
    if (ACC.strobe && !ACC.write) hold_mem[bidx[HPW-1:0] - HPW'(1)] <= MEM_RDATA;
  end

  assign WR_REQ = (hcnt != '0);
  assign BUSY   = (st != ST_IDLE);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_rd_strobe;
    ACC.strobe && !ACC.write;
  endsequence
  sequence s_wr_strobe;
    ACC.strobe && ACC.write;
  endsequence

  a_shared_no_overlap: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_rd_strobe |=> !ACC.write) else $error("write strobe right after read strobe");
  a_write_first: assert property (@(posedge CLK_SYS) disable iff (RST)
    st == ST_ARB |-> hcnt == '0) else $error("arbitration with data still held");
  a_wr_req_held: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_rd_strobe |-> ##1 WR_REQ) else $error("write request missing after read");
  a_shared_len: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_XFER && same && c.src_mem == MEM_SDRAM) |-> blen <= BURST_SDRAM) else $error("shared burst too long");
  a_port_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (s_wr_strobe ##1 (!ACC.strobe)[*1] ##1 s_wr_strobe) |->
      ACC.addr[AW-1:PORT_LSB] == $past(ACC.addr[AW-1:PORT_LSB], 2)) else $error("burst crossed a port");
  a_sync_seen: assert property (@(posedge CLK_SYS) disable iff (RST)
    go[1] |=> SYNC_SEEN[1]) else $error("sync seen flag late");
  // Flag set after the start edge, select shows eleven edges later
  sequence s_lead_select;
    st == ST_LEAD ##8 st == ST_SETUP ##1 ACC.select;
  endsequence
  a_sbs_lead: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_ARB && !last_vld && grant_vld && CFG[grant].src_mem == MEM_SYNC_BURST)
      |=> s_lead_select) else $error("burst sram lead not 11");
  a_sbs_pace: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_XFER && mem == MEM_SYNC_BURST && ecnt == '0) |=> ecnt == TW'(1) && !next_acc.strobe)
    else $error("burst sram element pace wrong");
  a_int_turn: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_HOLD && next_st == ST_TURN && same && c.src_mem == MEM_INT) |-> next_cnt == INT_RW_TURN)
    else $error("internal turn not 8");
  a_prio_grant: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_ARB && pend[0] && sync_set[0]) |=> cur == '0) else $error("auxiliary not granted first");

endmodule : dsrps_sched

// File: dv/dsrps_mem_model.sv
`timescale 1ns/100ps
module dsrps_mem_model
  import dsrps_pkg::*;
(
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  input  wire dsrps_acc_type ACC,
  input  wire logic [DW-1:0] SEED,
  output logic [DW-1:0]      MEM_RDATA
);
  logic [DW-1:0] last;
  logic [DW-1:0] next_last;

  // Data only while read strobe; else a flipping pattern so stale data is never seen
  always_comb begin
    MEM_RDATA = ~last;
    if (ACC.strobe && !ACC.write) begin
      MEM_RDATA = ACC.addr ^ SEED;
    end
    next_last = MEM_RDATA;
  end

  // Remember what went out last
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      last <= '0;
    end else begin
      last <= next_last;
    end
  end
endmodule : dsrps_mem_model

// File: dv/dsrps_sched_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module dsrps_sched_test
  import dsrps_pkg::*;
;
  logic                     CLK_SYS = 1'b0;
  logic                     RST = 1'b1;
  logic [NREQ-1:0]          START_WE = '0;
  logic [1:0]               START_VAL = 2'h0;
  dsrps_cfg_type [NREQ-1:0] CFG = '0;
  logic [DW-1:0]            SEED = 32'h0;
  logic [DW-1:0]            MEM_RDATA;
  dsrps_acc_type            ACC;
  logic [NREQ-1:0]          SYNC_SEEN;
  logic [NREQ-1:0]          DONE;
  logic                     WR_REQ;
  logic                     BUSY;
  int                       errors = 0;
  int                       checks_done = 0;
  logic [31:0]              rng = 32'h2f;
  logic [AW+DW-1:0]         wq [NREQ][$];
  int                       runq [NREQ][$];
  int                       rd_run [NREQ] = '{default: 0};
  logic [7:0]               run_port [NREQ];
  logic [NREQ-1:0]          last_wr = '1;
  logic [NREQ-1:0]          active = '0;
  logic                     got_rd = 1'b0;
  int                       c;
  int                       er;
  logic [AW+DW-1:0]         ew;
  int                       shared_len [5] = '{5, 3, 6, 5, 2};

  always #5 CLK_SYS = ~CLK_SYS;

  dsrps_sched i_dsrps_sched (.CLK_SYS(CLK_SYS), .RST(RST), .START_WE(START_WE), .START_VAL(START_VAL),
    .CFG(CFG), .MEM_RDATA(MEM_RDATA), .ACC(ACC), .SYNC_SEEN(SYNC_SEEN), .DONE(DONE), .WR_REQ(WR_REQ),
    .BUSY(BUSY));
  dsrps_mem_model i_dsrps_mem_model (.CLK_SYS(CLK_SYS), .RST(RST), .ACC(ACC), .SEED(SEED),
    .MEM_RDATA(MEM_RDATA));

  // --------
  // Helpers
  // --------
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic int room(logic [AW-1:0] a);
    return int'((32'h0100_0000 - {8'h0, a[23:0]}) >> 2);
  endfunction : room

  function automatic int burst(dsrps_cfg_type cf);
    if (cf.src_mem != cf.dst_mem) return 8;
    if (cf.src_mem == MEM_ASYNC) return (cf.async_read_hold == 2'h3) ? 2 : 3;
    return (cf.src_mem == MEM_SDRAM) ? 6 : 5;
  endfunction : burst

  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Notes every expected burst length and write, frame by frame
  task automatic plan(input int ch, input dsrps_cfg_type cf);
    int k;
    int n;
    logic [AW-1:0] s;
    logic [AW-1:0] d;
    s = cf.src_addr;
    d = cf.dst_addr;
    CFG[ch] = cf;
    for (int f = 0; f < int'(cf.frame_cnt); f++) begin
      k = int'(cf.elem_cnt);
      while (k > 0) begin
        n = burst(cf);
        n = (k < n) ? k : n;
        n = (room(s) < n) ? room(s) : n;
        n = (room(d) < n) ? room(d) : n;
        runq[ch].push_back(n);
        k -= n;
        repeat (n) begin
          wq[ch].push_back({d, s ^ SEED});
          s += 32'h4;
          d += 32'h4;
        end
      end
    end
  endtask : plan

  // A bad start value first, then a real start
  task automatic start(input int ch);
    rng = xs(rng);
    START_WE[ch] = 1'b1;
    START_VAL = (rng[1:0] == START_RUN) ? 2'h0 : rng[1:0];
    @(negedge CLK_SYS);
    `CHK("start_refused", 1'b0, SYNC_SEEN[ch])
    START_VAL = START_RUN;
    @(negedge CLK_SYS);
    START_WE[ch] = 1'b0;
    `CHK("sync_seen", 1'b1, SYNC_SEEN[ch])
  endtask : start

  task automatic run1(input int ch, input dsrps_mem_type sm, input dsrps_mem_type dm, input logic [AW-1:0] s,
                      input logic [AW-1:0] d, input int elem, input int frames, input logic [1:0] hold);
    rng = xs(rng);
    plan(ch, '{sm, dm, s, d, 16'(elem), 8'(frames), hold});
    start(ch);
  endtask : run1

  task automatic wait_done(input logic [NREQ-1:0] mask);
    logic [NREQ-1:0] seen;
    int n;
    seen = '0;
    n = 0;
    while ((seen !== mask || BUSY !== 1'b0) && n < 20000) begin
      @(negedge CLK_SYS);
      seen |= DONE;
      n++;
    end
    if (n >= 20000) begin
      errors++;
      summarize();
    end
    `CHK("wr_req_idle", 1'b0, WR_REQ)
    for (int i = 0; i < NREQ; i++) `CHK("notes_left", 0, wq[i].size() + runq[i].size())
  endtask : wait_done

  // Counts cycles until select or strobe shows, bounded
  task automatic cycles_to(input bit sel, input int want, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (!(sel ? ACC.select : ACC.strobe) && n < 64);
    `CHK(nm, want, n)
  endtask : cycles_to

  // Scoreboard: each strobe against the oldest note of its requester
  always @(posedge CLK_SYS) begin
    if (!RST && ACC.strobe) begin
      c = int'(ACC.chan);
      `CHK("prio_order", 5'h0, active & ((5'h1 << c) - 5'h1))
      if (ACC.write === last_wr[c]) `CHK("port", run_port[c], ACC.addr[31:24])
      run_port[c] = ACC.addr[31:24];
      last_wr[c] = ACC.write;
      active[c] = 1'b1;
      if (!ACC.write) begin
        rd_run[c]++;
        got_rd = 1'b1;
      end else begin
        if (rd_run[c] != 0) begin
          er = (runq[c].size() > 0) ? runq[c].pop_front() : 0;
          `CHK("burst_len", er, rd_run[c])
          rd_run[c] = 0;
        end
        ew = (wq[c].size() > 0) ? wq[c].pop_front() : '1;
        `CHK("write", ew, {ACC.addr, ACC.wdata})
      end
    end
    active &= ~DONE;
  end

  // Held data must raise a write request at once
  always @(negedge CLK_SYS) begin
    if (got_rd) `CHK("wr_req", 1'b1, WR_REQ)
    got_rd = 1'b0;
  end

  initial begin
    repeat (8) @(negedge CLK_SYS);
    RST = 1'b0;
    // One seed for the whole run, since channels overlap in the last scenario
    rng = xs(rng);
    SEED = rng;
    // Shared resource per memory type, frame of two bursts
    for (int m = 0; m < 5; m++) begin
      run1(1, (m == 4) ? MEM_ASYNC : dsrps_mem_type'(m), (m == 4) ? MEM_ASYNC : dsrps_mem_type'(m),
           {8'h10, 10'h0, rng[11:0], 2'h0}, {8'h10, 10'h1, rng[11:0], 2'h0}, 2 * shared_len[m], 1,
           (m == 4) ? 2'h3 : 2'h0);
      wait_done(5'h02);
    end
    run1(3, MEM_INT, MEM_INT, 32'h2000_0000, 32'h2000_1000, 3, 2, 2'h0);
    wait_done(5'h08);
    run1(4, MEM_INT, MEM_SYNC_BURST, 32'h00ff_fff8, 32'h80ff_ffec, 8, 1, 2'h0);
    wait_done(5'h10);
    // Read timing of the half-rate burst memory from idle
    run1(1, MEM_SYNC_BURST, MEM_INT, 32'h3000_0000, 32'h0000_4000, 4, 2, 2'h0);
    cycles_to(1'b1, 11, "sync_to_select");
    cycles_to(1'b0, 4, "select_to_data");
    cycles_to(1'b0, 2, "elem_spacing");
    wait_done(5'h02);
    // Higher requesters arrive while a low one bursts
    run1(2, MEM_SDRAM, MEM_INT, 32'h4000_0000, 32'h0000_8000, 16, 1, 2'h0);
    repeat (20) @(negedge CLK_SYS);
    run1(0, MEM_INT, MEM_INT, 32'h0000_c000, 32'h0000_d000, 5, 1, 2'h0);
    run1(1, MEM_SYNC_BURST, MEM_INT, 32'h5000_0000, 32'h0000_e000, 6, 1, 2'h0);
    wait_done(5'h07);
    summarize();
  end
endmodule : dsrps_sched_test
